/* File: hw/cwr_pkg.sv */
// Purpose: shared constants and types for the configuration word and reset control block
// Assumes: 40 MHz mclk, 14-bit configuration word
// Notes:   all offsets, fields and counts live here
package cwr_pkg;
  localparam int unsigned CLK_HZ             = 40_000_000;
  localparam int unsigned POWER_UP_DELAY_TIMER_MS            = 64;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES        = (CLK_HZ / 1000) * POWER_UP_DELAY_TIMER_MS;
  localparam int unsigned MASTER_CLEAR_PIN_FILT_NS       = 2000;
  localparam int unsigned MASTER_CLEAR_PIN_FILT_CYCLES   = (MASTER_CLEAR_PIN_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [13:0] CFG_SPACE_LO       = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI       = 14'h3FFF;
  localparam logic [13:0] CFG_WORD_ADDR      = 14'h2007;
  localparam logic [13:0] CAL_WORD_ADDR      = 14'h2008;
  localparam logic [13:0] CFG_ERASED         = 14'h3FFF;
  localparam logic [13:0] CAL_DEFAULT        = 14'h1000;
  localparam logic [13:0] CFG_UNIMPL_MASK    = 14'h0086;

  localparam int unsigned BIT_DEBUG          = 13;
  localparam int unsigned BIT_CLOCK_OUTPUT_PIN_EN      = 12;
  localparam int unsigned BIT_WRT_HI         = 11;
  localparam int unsigned BIT_WRT_LO         = 10;
  localparam int unsigned BIT_BOR_HI         = 9;
  localparam int unsigned BIT_BOR_LO         = 8;
  localparam int unsigned BIT_CODE_PROTECT   = 6;
  localparam int unsigned BIT_MASTER_CLEAR_PIN_SEL       = 5;
  localparam int unsigned BIT_POWER_UP_DELAY_TIMER_DIS       = 4;
  localparam int unsigned BIT_WDT_EN         = 3;
  localparam int unsigned BIT_OSC_SEL        = 0;

  localparam logic [1:0]  WRT_NONE           = 2'h3;
  localparam logic [1:0]  WRT_LOW256         = 2'h2;
  localparam logic [1:0]  WRT_LOW512         = 2'h1;
  localparam logic [9:0]  WRT_LIMIT_256      = 10'h0FF;
  localparam logic [9:0]  WRT_LIMIT_512      = 10'h1FF;
  localparam logic [1:0]  BOR_ALWAYS         = 2'h3;
  localparam logic [1:0]  BOR_RUN_ONLY       = 2'h2;

  typedef struct packed {
    logic       debug_enable;
    logic       clock_output_enable;
    logic [1:0] self_write_protect;
    logic [1:0] brownout_mode_select;
    logic       code_protect;
    logic       master_clear_pin_select;
    logic       power_up_delay_disable;
    logic       watchdog_enable_bit;
    logic       external_clock_mode;
  } cwr_cfg_t;

  typedef struct packed {
    logic por_flag_n;
    logic bor_flag_n;
    logic watchdog_expiry_flag;
    logic powered_down_flag;
  } cwr_flags_t;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10,
    ST_SLEEP = 2'b11
  } cwr_state_t;
endpackage

/* File: hw/cwr_glitch_filter.sv */
// Purpose: glitch filter for the master-clear pin level
// Assumes: pin level already synchronous to mclk
// Notes:   output follows input only after a stable run
`timescale 1ns/1ps
module cwr_glitch_filter
  import cwr_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  output logic      level_out
);
  localparam int unsigned CW = $clog2(MASTER_CLEAR_PIN_FILT_CYCLES + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(MASTER_CLEAR_PIN_FILT_CYCLES);

  logic [CW-1:0] stable_cnt;
  logic          filt;
  wire           differs    = (level_in != filt);
  wire           long_enough = (stable_cnt >= FILT_MAX);

  // short pulses reset the count and never reach the output
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stable_cnt <= '0;
      filt       <= 1'b1;
    end else if (!differs) begin
      stable_cnt <= '0;
    end else if (long_enough) begin
      filt       <= level_in;
      stable_cnt <= '0;
    end else begin
      stable_cnt <= stable_cnt + CW'(1);
    end
  end

  assign level_out = filt;
endmodule

/* File: hw/cwr_reset_ctrl.sv */
// Purpose: configuration word decode, reset sequencing and reset-cause flags
// Assumes: supply monitors and pin levels synchronous to mclk; mclk runs from the internal rc
// Notes:   internal reset asserts combinationally except from the filtered master-clear pin, releases on a clock edge
`timescale 1ns/1ps
module cwr_reset_ctrl
  import cwr_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_COUNT = POWER_UP_DELAY_TIMER_CYCLES
)(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        por_in,
  input  wire logic        brownout_in,
  input  wire logic        watchdog_timeout_in,
  input  wire logic        interrupt_wake_in,
  input  wire logic        sleep_req_in,
  input  wire logic        master_clear_pin_in,
  input  wire logic        prog_mode_in,
  input  wire logic        prog_wr_in,
  input  wire logic        prog_bulk_erase_in,
  input  wire logic [13:0] prog_addr_in,
  input  wire logic [13:0] prog_wdata_in,
  input  wire logic        flag_wr_in,
  input  wire logic        flag_por_set_in,
  input  wire logic        flag_bor_set_in,
  input  wire logic [9:0]  flash_wr_addr_in,
  input  wire logic        clock_output_pin_io_in,
  output logic [13:0]      prog_rdata_out,
  output logic             prog_rvalid_out,
  output logic             reset_out,
  output logic             wake_out,
  output logic             in_sleep_out,
  output cwr_flags_t       flags_out,
  output cwr_cfg_t         cfg_out,
  output logic             flash_wr_allow_out,
  output logic             brownout_active_out,
  output logic             master_clear_pullup_out,
  output logic             master_clear_level_out,
  output logic             clock_output_pin_out,
  output logic             clock_output_pin_oe_out,
  output logic             use_ext_clock_out
);
  localparam int unsigned PW = $clog2(POWER_UP_DELAY_TIMER_COUNT + 1);
  localparam logic [PW-1:0] POWER_UP_DELAY_TIMER_LAST = PW'(POWER_UP_DELAY_TIMER_COUNT - 1);

  function automatic logic in_cfg_space(input logic [13:0] a);
    in_cfg_space = (a >= CFG_SPACE_LO) && (a <= CFG_SPACE_HI);
  endfunction

  logic [13:0]   cfg_word;
  logic [13:0]   cal_word;
  logic [13:0]   prog_rdata;
  logic          prog_rvalid;
  cwr_state_t    state;
  cwr_state_t    next_state;
  logic [PW-1:0] delay_cnt;
  logic          rst_hold;
  logic          wake_q;
  logic          clk_div;
  cwr_flags_t    flags;
  logic          master_clear_pin_filt;

  wire [13:0] cfg_view = cfg_word | CFG_UNIMPL_MASK;

  // decode of each field, 0 means programmed
  assign cfg_out.debug_enable            = ~cfg_view[BIT_DEBUG];
  assign cfg_out.clock_output_enable     = ~cfg_view[BIT_CLOCK_OUTPUT_PIN_EN];
  assign cfg_out.self_write_protect      = cfg_view[BIT_WRT_HI:BIT_WRT_LO];
  assign cfg_out.brownout_mode_select    = cfg_view[BIT_BOR_HI:BIT_BOR_LO];
  assign cfg_out.code_protect            = ~cfg_view[BIT_CODE_PROTECT];
  assign cfg_out.master_clear_pin_select = cfg_view[BIT_MASTER_CLEAR_PIN_SEL];
  assign cfg_out.power_up_delay_disable  = cfg_view[BIT_POWER_UP_DELAY_TIMER_DIS];
  assign cfg_out.watchdog_enable_bit     = cfg_view[BIT_WDT_EN];
  assign cfg_out.external_clock_mode     = cfg_view[BIT_OSC_SEL];
  assign use_ext_clock_out               = cfg_view[BIT_OSC_SEL];

  wire wrt_blocked = (cfg_out.self_write_protect == WRT_NONE)   ? 1'b0 :
                     (cfg_out.self_write_protect == WRT_LOW256) ? (flash_wr_addr_in <= WRT_LIMIT_256) :
                     (cfg_out.self_write_protect == WRT_LOW512) ? (flash_wr_addr_in <= WRT_LIMIT_512) :
                     1'b1;
  assign flash_wr_allow_out = ~wrt_blocked;

  assign master_clear_pullup_out = cfg_out.master_clear_pin_select;
  assign master_clear_level_out  = master_clear_pin_in;

  // short pulses on the pin are dropped
  cwr_glitch_filter u_master_clear_pin_filt (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .level_in  (master_clear_pin_in),
    .level_out (master_clear_pin_filt)
  );

  wire sleeping = (state == ST_SLEEP);

  // brown-out mode, run-only mode idles in sleep
  assign brownout_active_out = (cfg_out.brownout_mode_select == BOR_ALWAYS) ||
                               ((cfg_out.brownout_mode_select == BOR_RUN_ONLY) && !sleeping);
  wire bor_evt  = brownout_in && brownout_active_out;
  // master-clear from the pin only when the select bit is set; as a plain input the pin does nothing
  wire master_clear_pin_evt = cfg_out.master_clear_pin_select && !master_clear_pin_filt;
  wire wdt_evt  = watchdog_timeout_in && cfg_out.watchdog_enable_bit;
  wire wdt_rst  = wdt_evt && (state == ST_RUN);
  // watchdog in sleep is a wake, not a reset
  wire wdt_wake = wdt_evt && sleeping;
  wire int_wake = interrupt_wake_in && sleeping;
  wire pwr_evt  = por_in || bor_evt;
  // every source asserts reset with no clock, except the master-clear pin, which first passes its clocked filter
  wire raw_rst  = pwr_evt || master_clear_pin_evt || wdt_rst;

  // delay only from power events and when enabled
  // only its own bit gates the delay
  wire delay_en = !cfg_out.power_up_delay_disable;
  wire delay_done = (delay_cnt == POWER_UP_DELAY_TIMER_LAST);

  // two wake sources, watchdog and interrupt; master-clear wakes through reset
  // wake goes straight to run, no delay
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!raw_rst) begin
          next_state = ST_RUN;
        end
      end
      ST_DELAY: begin
        // brown-out during the delay restarts it
        if (pwr_evt) begin
          next_state = ST_HOLD;
        end else if (delay_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_RUN: begin
        if (sleep_req_in && !raw_rst) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wdt_wake || int_wake) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_HOLD;
    endcase
    if (pwr_evt) begin
      next_state = ST_HOLD;
    end else if (master_clear_pin_evt && state != ST_DELAY) begin
      next_state = ST_HOLD;
    end
  end

  // tracks whether the current hold came from a power event
  logic pwr_pending;
  wire  to_delay = (state == ST_HOLD) && !raw_rst && pwr_pending && delay_en;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state       <= ST_HOLD;
      pwr_pending <= 1'b1;
      delay_cnt   <= '0;
    end else begin
      state <= to_delay ? ST_DELAY : next_state;
      if (pwr_evt) begin
        pwr_pending <= 1'b1;
      end else if (state == ST_HOLD && !raw_rst) begin
        pwr_pending <= 1'b0;
      end
      if (state != ST_DELAY || pwr_evt) begin
        delay_cnt <= '0;
      end else if (!delay_done) begin
        delay_cnt <= delay_cnt + PW'(1);
      end
    end
  end

  // release waits for a clock edge
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rst_hold <= 1'b1;
    end else begin
      rst_hold <= raw_rst || (next_state == ST_HOLD) || to_delay || (state == ST_DELAY);
    end
  end
  // consumers reset state on this for all reset kinds
  assign reset_out = raw_rst || rst_hold;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wdt_wake || int_wake;
    end
  end
  assign wake_out     = wake_q;
  assign in_sleep_out = sleeping;

  // flags per source; hardware clear beats software set
  // power-on flag only touched by power-on and software
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      flags <= '{por_flag_n: 1'b0, bor_flag_n: 1'b1, watchdog_expiry_flag: 1'b1, powered_down_flag: 1'b1};
    end else if (por_in) begin
      flags.por_flag_n           <= 1'b0;
      flags.watchdog_expiry_flag <= 1'b1;
      flags.powered_down_flag    <= 1'b1;
    end else if (bor_evt) begin
      flags.bor_flag_n           <= 1'b0;
      flags.watchdog_expiry_flag <= 1'b1;
      flags.powered_down_flag    <= 1'b1;
      if (flag_wr_in && flag_por_set_in) begin
        flags.por_flag_n <= 1'b1;
      end
    end else begin
      if (flag_wr_in && flag_por_set_in) begin
        flags.por_flag_n <= 1'b1;
      end
      if (flag_wr_in && flag_bor_set_in) begin
        flags.bor_flag_n <= 1'b1;
      end
      if (wdt_rst) begin
        flags.watchdog_expiry_flag <= 1'b0;
      end else if (wdt_wake) begin
        flags.watchdog_expiry_flag <= 1'b0;
        flags.powered_down_flag    <= 1'b0;
      end else if (master_clear_pin_evt && sleeping) begin
        flags.watchdog_expiry_flag <= 1'b1;
        flags.powered_down_flag    <= 1'b0;
      end
    end
  end
  assign flags_out = flags;

  // access only in programming mode and config space
  wire prog_hit = prog_mode_in && in_cfg_space(prog_addr_in);
  wire hit_cfg  = prog_hit && (prog_addr_in == CFG_WORD_ADDR);
  wire hit_cal  = prog_hit && (prog_addr_in == CAL_WORD_ADDR);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_word <= CFG_ERASED;
      cal_word <= CAL_DEFAULT;
    end else if (prog_mode_in && prog_bulk_erase_in) begin
      cfg_word <= CFG_ERASED;
    end else if (prog_wr_in && hit_cfg) begin
      cfg_word <= prog_wdata_in;
    end else if (prog_wr_in && hit_cal) begin
      cal_word <= prog_wdata_in;
    end
  end

  // unimplemented bits read back as 1
  wire [13:0] next_rdata = hit_cfg ? cfg_view : (hit_cal ? cal_word : 14'h0000);
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prog_rdata  <= 14'h0000;
      prog_rvalid <= 1'b0;
    end else begin
      prog_rdata  <= next_rdata;
      prog_rvalid <= prog_hit && !prog_wr_in;
    end
  end
  assign prog_rdata_out  = prog_rdata;
  assign prog_rvalid_out = prog_rvalid;

  // divided clock on the pin when enabled, else I/O
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      clk_div <= 1'b0;
    end else begin
      clk_div <= ~clk_div;
    end
  end
  assign clock_output_pin_out    = cfg_out.clock_output_enable ? clk_div : clock_output_pin_io_in;
  assign clock_output_pin_oe_out = cfg_out.clock_output_enable;

  // no pin drive exists on the master-clear path
endmodule

/* File: dv/cwr_reset_ctrl_asserts.sv */
// Purpose: port-level checker for the configuration word and reset control block
// Assumes: one clock domain, synchronous active-high rst_in
// Notes:   bound onto every cwr_reset_ctrl instance
`timescale 1ns/1ps
module cwr_reset_ctrl_chk
  import cwr_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        por_in,
  input wire logic        brownout_in,
  input wire logic        watchdog_timeout_in,
  input wire logic        interrupt_wake_in,
  input wire logic        master_clear_pin_in,
  input wire logic        prog_mode_in,
  input wire logic [13:0] prog_addr_in,
  input wire logic [9:0]  flash_wr_addr_in,
  input wire logic        clock_output_pin_io_in,
  input wire logic [13:0] prog_rdata_out,
  input wire logic        prog_rvalid_out,
  input wire logic        reset_out,
  input wire logic        wake_out,
  input wire logic        in_sleep_out,
  input wire cwr_flags_t  flags_out,
  input wire cwr_cfg_t    cfg_out,
  input wire logic        flash_wr_allow_out,
  input wire logic        brownout_active_out,
  input wire logic        master_clear_pullup_out,
  input wire logic        master_clear_level_out,
  input wire logic        clock_output_pin_out,
  input wire logic        clock_output_pin_oe_out,
  input wire logic        use_ext_clock_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_unimpl_ones;
    prog_rvalid_out && $past(prog_addr_in) == CFG_WORD_ADDR |-> prog_rdata_out[7] && (&prog_rdata_out[2:1]);
  endproperty
  a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bits not read as one");
  property p_prog_only;
    !$past(prog_mode_in) |-> !prog_rvalid_out && prog_rdata_out == 14'h0000;
  endproperty
  a_prog_only: assert property (p_prog_only) else $error("config space answered outside programming");
  property p_clk_pin;
    !cfg_out.clock_output_enable |-> !clock_output_pin_oe_out && clock_output_pin_out == clock_output_pin_io_in;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock pin not general io");
  property p_wr_range;
    flash_wr_allow_out == (cfg_out.self_write_protect == WRT_NONE
      || (cfg_out.self_write_protect == WRT_LOW256 && flash_wr_addr_in > WRT_LIMIT_256)
      || (cfg_out.self_write_protect == WRT_LOW512 && flash_wr_addr_in > WRT_LIMIT_512));
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("self-write range wrong");
  property p_bor_mode;
    brownout_active_out == (cfg_out.brownout_mode_select == BOR_ALWAYS
      || (cfg_out.brownout_mode_select == BOR_RUN_ONLY && !in_sleep_out));
  endproperty
  a_bor_mode: assert property (p_bor_mode) else $error("brown-out enable wrong");
  property p_pullup;
    master_clear_pullup_out == cfg_out.master_clear_pin_select && use_ext_clock_out == cfg_out.external_clock_mode;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pin function select wrong");
  property p_async_rst;
    por_in || (brownout_in && brownout_active_out) |-> reset_out;
  endproperty
  a_async_rst: assert property (p_async_rst) else $error("reset not asserted at once");
  property p_int_wake;
    in_sleep_out && interrupt_wake_in && !reset_out |=> !in_sleep_out && wake_out && !reset_out;
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("interrupt did not wake");
  property p_por_flag;
    $fell(flags_out.por_flag_n) |-> $past(por_in);
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag cleared without power-on");
  property p_pin_free;
    watchdog_timeout_in |-> ##[0:3] master_clear_level_out == master_clear_pin_in;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("master-clear level disturbed");
endmodule

bind cwr_reset_ctrl cwr_reset_ctrl_chk u_chk (.*);

/* File: dv/cwr_pin_supply_model.sv */
// Purpose: far side model: supply monitors and the master-clear pin
// Assumes: requests come from the bench at rising mclk
// Notes:   analog thresholds reduced to plain request levels
`timescale 1ns/1ps
module cwr_pin_supply_model (
  input  wire logic por_req_in,
  input  wire logic bor_req_in,
  input  wire logic master_clear_pin_drive_low_in,
  output logic      por_out,
  output logic      brownout_out,
  output logic      master_clear_pin_out
);
  assign por_out      = por_req_in;
  assign brownout_out = bor_req_in;
  // weak pull-up
  // undriven pin rests high, never floats
  assign master_clear_pin_out = master_clear_pin_drive_low_in ? 1'b0 : 1'b1;
endmodule

/* File: dv/tb.sv */
// Purpose: self-checking bench for cwr_reset_ctrl
// Assumes: POWER_UP_DELAY_TIMER_COUNT shortened to 20 cycles
// Notes:   flag values compared as {por_n, bor_n, expiry, powered_down}
`timescale 1ns/1ps
module tb;
  import cwr_pkg::*;
  localparam int PW = 20;
  logic        mclk_in = 0, rst_in = 1, watchdog_timeout_in = 0, interrupt_wake_in = 0, sleep_req_in = 0;
  logic        prog_mode_in = 0, prog_wr_in = 0, prog_bulk_erase_in = 0, flag_wr_in = 0;
  logic        flag_por_set_in = 0, flag_bor_set_in = 0, clock_output_pin_io_in = 1;
  logic        por_req = 0, bor_req = 0, master_clear_pin_low = 0;
  logic [13:0] prog_addr_in = 14'h0000, prog_wdata_in = 14'h0000;
  logic [9:0]  flash_wr_addr_in = 10'h0A0;
  wire         por_in, brownout_in, master_clear_pin_in;
  wire  [13:0] prog_rdata_out;
  wire         prog_rvalid_out, reset_out, wake_out, in_sleep_out, flash_wr_allow_out, brownout_active_out;
  wire         master_clear_pullup_out, master_clear_level_out, clock_output_pin_out;
  wire         clock_output_pin_oe_out, use_ext_clock_out;
  cwr_flags_t  flags_out;
  cwr_cfg_t    cfg_out;
  int          num_errors = 0, n_checks = 0, n;

  cwr_reset_ctrl #(.POWER_UP_DELAY_TIMER_COUNT(PW)) uut (.*);
  cwr_pin_supply_model u_far (.por_req_in(por_req), .bor_req_in(bor_req), .master_clear_pin_drive_low_in(master_clear_pin_low),
    .por_out(por_in), .brownout_out(brownout_in), .master_clear_pin_out(master_clear_pin_in));

  always #12.5 mclk_in = ~mclk_in;

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task prd(input logic [13:0] a);
    @(posedge mclk_in) prog_addr_in <= a;
    tick(1);
  endtask
  task pwr(input logic [13:0] a, input logic [13:0] d);
    @(posedge mclk_in) prog_addr_in <= a;
    prog_wdata_in <= d;
    prog_wr_in <= 1;
    @(posedge mclk_in) prog_wr_in <= 0;
  endtask
  task rst_len;
    n = 0;
    while (reset_out !== 1'b0 && n < 600) begin
      tick(1);
      n++;
    end
  endtask
  task sleep_now;
    @(posedge mclk_in) sleep_req_in <= 1;
    @(posedge mclk_in) sleep_req_in <= 0;
    tick(2);
    chk(in_sleep_out, 1, "not asleep");
  endtask
  task done_test(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    $display("CHECK FAILED t=%0t run hung", $time);
    finish_test;
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 0;
    rst_len;
    chk({10'h000, flags_out}, 14'h0007, "power-up flags");
    chk({3'h0, cfg_out}, 14'h01EF, "erased decode");
    done_test("power-up");
    prd(CFG_WORD_ADDR);
    chk({prog_rvalid_out, prog_rdata_out}, 15'h0000, "read outside mode");
    @(posedge mclk_in) prog_mode_in <= 1;
    prd(CFG_WORD_ADDR);
    chk(prog_rdata_out, 14'h3FFF, "erased word");
    prd(14'h1FFF);
    chk(prog_rvalid_out, 0, "read outside space");
    pwr(CFG_WORD_ADDR, 14'h0000);
    prog_bulk_erase_in <= 1;
    @(posedge mclk_in) prog_bulk_erase_in <= 0;
    prd(CFG_WORD_ADDR);
    chk(prog_rdata_out, 14'h3FFF, "word after erase");
    prd(CAL_WORD_ADDR);
    chk(prog_rdata_out, CAL_DEFAULT, "calibration kept");
    done_test("programming");
    @(posedge mclk_in) bor_req <= 1;
    tick(3);
    chk(reset_out, 1, "brown-out reset");
    @(posedge mclk_in) bor_req <= 0;
    rst_len;
    chk(n < PW, 1, "delay disabled");
    chk({10'h000, flags_out}, 14'h0003, "brown-out flags");
    done_test("brown-out no delay");
    pwr(CFG_WORD_ADDR, 14'h2768);
    prd(CFG_WORD_ADDR);
    chk(prog_rdata_out, 14'h27EE, "programmed word");
    chk({3'h0, cfg_out}, 14'h02EA, "field decode");
    chk(clock_output_pin_oe_out, 1, "clock driven out");
    @(posedge mclk_in) prog_mode_in <= 0;
    flash_wr_addr_in <= 10'h250;
    clock_output_pin_io_in <= 0;
    flag_wr_in <= 1;
    flag_por_set_in <= 1;
    flag_bor_set_in <= 1;
    @(posedge mclk_in) flag_wr_in <= 0;
    tick(1);
    chk({10'h000, flags_out}, 14'h000F, "software flag set");
    chk(flash_wr_allow_out, 1, "above protected range");
    done_test("configure");
    @(posedge mclk_in) bor_req <= 1;
    tick(2);
    @(posedge mclk_in) bor_req <= 0;
    tick(8);
    @(posedge mclk_in) bor_req <= 1;
    tick(2);
    @(posedge mclk_in) bor_req <= 0;
    rst_len;
    chk(n >= PW && n < PW + 10, 1, "fresh delay");
    chk({10'h000, flags_out}, 14'h000B, "brown-out flags");
    done_test("brown-out restart");
    @(posedge mclk_in) watchdog_timeout_in <= 1;
    @(posedge mclk_in) watchdog_timeout_in <= 0;
    #1;
    chk(reset_out, 1, "watchdog reset");
    rst_len;
    chk(n < PW, 1, "no delay after watchdog");
    chk({10'h000, flags_out}, 14'h0009, "watchdog flags");
    done_test("watchdog reset");
    sleep_now;
    @(posedge mclk_in) watchdog_timeout_in <= 1;
    @(posedge mclk_in) watchdog_timeout_in <= 0;
    #1;
    chk(wake_out, 1, "wake pulse");
    tick(3);
    chk({reset_out, in_sleep_out}, 2'b00, "watchdog wake");
    chk({10'h000, flags_out}, 14'h0008, "wake flags");
    sleep_now;
    @(posedge mclk_in) flash_wr_addr_in <= 10'h150;
    @(posedge mclk_in) interrupt_wake_in <= 1;
    @(posedge mclk_in) interrupt_wake_in <= 0;
    tick(2);
    chk({reset_out, in_sleep_out}, 2'b00, "interrupt wake");
    chk(flash_wr_allow_out, 0, "low range blocked");
    done_test("wake-up");
    @(posedge mclk_in) master_clear_pin_low <= 1;
    repeat (10) begin
      tick(1);
      chk(reset_out, 0, "glitch ignored");
    end
    @(posedge mclk_in) master_clear_pin_low <= 0;
    sleep_now;
    @(posedge mclk_in) master_clear_pin_low <= 1;
    tick(100);
    chk(reset_out, 1, "master-clear reset");
    @(posedge mclk_in) master_clear_pin_low <= 0;
    rst_len;
    chk({10'h000, flags_out}, 14'h000A, "sleep clear flags");
    done_test("master clear");
    @(posedge mclk_in) por_req <= 1;
    tick(3);
    @(posedge mclk_in) por_req <= 0;
    rst_len;
    chk(n >= PW && n < PW + 10, 1, "power-up delay");
    chk({10'h000, flags_out}, 14'h0003, "power-on flags");
    done_test("power-on");
    @(posedge mclk_in) prog_mode_in <= 1;
    pwr(CFG_WORD_ADDR, 14'h3AD7);
    @(posedge mclk_in) prog_mode_in <= 0;
    tick(1);
    chk({3'h0, cfg_out}, 14'h0145, "second decode");
    chk(use_ext_clock_out, 1, "external clock");
    chk(flash_wr_allow_out, 1, "above low range");
    chk(brownout_active_out, 1, "brown-out while running");
    sleep_now;
    chk(brownout_active_out, 0, "brown-out off in sleep");
    @(posedge mclk_in) bor_req <= 1;
    tick(2);
    chk({reset_out, in_sleep_out}, 2'b01, "no brown-out in sleep");
    @(posedge mclk_in) bor_req <= 0;
    watchdog_timeout_in <= 1;
    @(posedge mclk_in) watchdog_timeout_in <= 0;
    tick(2);
    chk({reset_out, in_sleep_out}, 2'b01, "watchdog disabled");
    @(posedge mclk_in) master_clear_pin_low <= 1;
    tick(100);
    chk({reset_out, in_sleep_out}, 2'b01, "pin is plain input");
    @(posedge mclk_in) master_clear_pin_low <= 0;
    done_test("second config");
    finish_test;
  end
endmodule
